//--- rtl/hdlc_fifo_ctrl2.sv
// HDLC FIFO status register, second control register and transmit path.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - TX FIFO code: 00 at status level, 01 at threshold, 10 empty, 11 below.
// - RX FIFO fill code sits in status bits 1 and 0.
// - Interrupt bit 2 shows underrun when select is one, frame abort when zero.
// - Cycle bit one makes the byte counter reload its loaded count repeatedly.
// - CRC inhibit one suppresses the FCS after an end-of-packet byte.
// - Seven-bit mode compares only seven bits of the first address byte.
// - Seven-bit mode accepts the address only if received bit 0 is one.
module hdlc_fifo_ctrl2 (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	output logic            tx_fifo_ready_o,
	output logic [7:0]      tx_byte_o,
	output logic            tx_valid_o,
	output logic            tx_packet_end_tag_o,
	output logic            tx_fcs_o,
	input  wire logic       tx_ready_i,
	output logic            irq_bit2_o,
	output logic            byte_cnt_wrap_o,
	input  wire logic [5:0] rx_level_i,
	input  wire logic [7:0] rx_byte_i,
	input  wire logic       rx_first_i,
	input  wire logic       rx_valid_i,
	output logic            addr_match_o
);
	byte_fifo_if #(.WIDTH(hdlc_ctl_pkg::FIFO_W), .LVL_W(hdlc_ctl_pkg::LEVEL_W)) txq ();

	logic [7:0]                 ctrl2;
	logic                       tag_eop;
	logic                       tag_abort;
	logic [7:0]                 cnt_load;
	logic [7:0]                 byte_cnt;
	logic [7:0]                 rx_addr;
	logic [5:0]                 stat_lvl;
	logic [5:0]                 int_thr;
	hdlc_ctl_pkg::tx_state_type state;
	logic                       held_eop;
	logic                       held_abort;
	logic [1:0]                 tx_code;
	logic [1:0]                 rx_code;
	logic                       fifo_wr;
	logic                       byte_done;
	logic                       underrun;
	logic                       abort_ev;
	logic                       addr_hit;

	// Maps an occupancy to empty, below, at-threshold and at-status-level classes.
	function automatic logic [1:0] fill_class(input logic [5:0] lvl, input logic [5:0] st,
	                                          input logic [5:0] thr);
		if (lvl == 6'h00) begin
			fill_class = 2'h0;
		end else if (lvl >= st) begin
			fill_class = 2'h3;
		end else if (lvl >= thr) begin
			fill_class = 2'h2;
		end else begin
			fill_class = 2'h1;
		end
	endfunction : fill_class

	// Status codes are decoded from occupancy with separate encodings per FIFO.
	always_comb begin
		case (fill_class(txq.level, stat_lvl, int_thr))
			2'h0:    tx_code = hdlc_ctl_pkg::TX_EMPTY;
			2'h3:    tx_code = hdlc_ctl_pkg::TX_FULL;
			2'h2:    tx_code = hdlc_ctl_pkg::TX_ABOVE_THR;
			default: tx_code = hdlc_ctl_pkg::TX_BELOW_THR;
		endcase
		case (fill_class(rx_level_i, stat_lvl, int_thr))
			2'h0:    rx_code = hdlc_ctl_pkg::RX_EMPTY;
			2'h3:    rx_code = hdlc_ctl_pkg::RX_FULL;
			2'h2:    rx_code = hdlc_ctl_pkg::RX_ABOVE_THR;
			default: rx_code = hdlc_ctl_pkg::RX_BELOW_THR;
		endcase
	end

	// A write to the TX FIFO address pushes the byte with its pending tags.
	assign fifo_wr       = wr_i && (addr_i == hdlc_ctl_pkg::OFS_TX_FIFO);
	assign txq.in_valid  = fifo_wr;
	assign txq.in_data   = {tag_abort, tag_eop, wdata_i};
	assign txq.out_ready = (state == hdlc_ctl_pkg::TX_IDLE);
	assign byte_done     = (state == hdlc_ctl_pkg::TX_SEND) && tx_ready_i;
	assign underrun      = byte_done && !held_eop && !held_abort && !txq.out_valid;
	assign abort_ev      = byte_done && held_abort;

	byte_fifo #(
		.WIDTH (hdlc_ctl_pkg::FIFO_W),
		.DEPTH (hdlc_ctl_pkg::FIFO_DEPTH),
		.LVL_W (hdlc_ctl_pkg::LEVEL_W)
	) u_tx_fifo (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.fifo    (txq)
	);

	// Software registers; the end and abort tags clear after the next FIFO write.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl2     <= hdlc_ctl_pkg::CTRL2_RESET;
			tag_eop   <= 1'b0;
			tag_abort <= 1'b0;
			cnt_load  <= hdlc_ctl_pkg::ZERO_BYTE;
			rx_addr   <= hdlc_ctl_pkg::ZERO_BYTE;
			stat_lvl  <= hdlc_ctl_pkg::STAT_LVL_RST;
			int_thr   <= hdlc_ctl_pkg::INT_THR_RST;
		end else if (wr_i) begin
			case (addr_i)
				hdlc_ctl_pkg::OFS_TX_FIFO: begin
					tag_eop   <= 1'b0;
					tag_abort <= 1'b0;
				end
				hdlc_ctl_pkg::OFS_CTRL1: begin
					tag_eop   <= wdata_i[hdlc_ctl_pkg::C1_EOP_BIT];
					tag_abort <= wdata_i[hdlc_ctl_pkg::C1_ABORT_BIT];
				end
				hdlc_ctl_pkg::OFS_CTRL2:    ctrl2    <= wdata_i;
				hdlc_ctl_pkg::OFS_BYTE_CNT: cnt_load <= wdata_i;
				hdlc_ctl_pkg::OFS_ADDR:     rx_addr  <= wdata_i;
				hdlc_ctl_pkg::OFS_STAT_LVL: stat_lvl <= wdata_i[5:0];
				hdlc_ctl_pkg::OFS_INT_THR:  int_thr  <= wdata_i[5:0];
				default: begin
				end
			endcase
		end
	end

	// Read data is registered; unmapped addresses return zero.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rdata_o <= hdlc_ctl_pkg::ZERO_BYTE;
		end else if (rd_i) begin
			case (addr_i)
				hdlc_ctl_pkg::OFS_STATUS:   rdata_o <= {4'h0, tx_code, rx_code};
				hdlc_ctl_pkg::OFS_CTRL2:    rdata_o <= ctrl2;
				hdlc_ctl_pkg::OFS_BYTE_CNT: rdata_o <= byte_cnt;
				hdlc_ctl_pkg::OFS_ADDR:     rdata_o <= rx_addr;
				hdlc_ctl_pkg::OFS_STAT_LVL: rdata_o <= {2'h0, stat_lvl};
				hdlc_ctl_pkg::OFS_INT_THR:  rdata_o <= {2'h0, int_thr};
				default:                    rdata_o <= hdlc_ctl_pkg::ZERO_BYTE;
			endcase
		end
	end

	// Transmit sequencer: one byte at a time, then an optional FCS slot.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state               <= hdlc_ctl_pkg::TX_IDLE;
			tx_byte_o           <= hdlc_ctl_pkg::ZERO_BYTE;
			tx_valid_o          <= 1'b0;
			tx_packet_end_tag_o <= 1'b0;
			tx_fcs_o            <= 1'b0;
			held_eop            <= 1'b0;
			held_abort          <= 1'b0;
		end else begin
			case (state)
				hdlc_ctl_pkg::TX_IDLE: begin
					if (txq.out_valid) begin
						tx_byte_o           <= txq.out_data[7:0];
						tx_valid_o          <= 1'b1;
						tx_packet_end_tag_o <= txq.out_data[hdlc_ctl_pkg::TAG_EOP_BIT];
						held_eop            <= txq.out_data[hdlc_ctl_pkg::TAG_EOP_BIT];
						held_abort          <= txq.out_data[hdlc_ctl_pkg::TAG_ABORT_BIT];
						state               <= hdlc_ctl_pkg::TX_SEND;
					end
				end
				hdlc_ctl_pkg::TX_SEND: begin
					if (tx_ready_i) begin
						tx_valid_o          <= 1'b0;
						tx_packet_end_tag_o <= 1'b0;
						if (held_eop && !held_abort && !ctrl2[hdlc_ctl_pkg::C2_CRCINH_BIT]) begin
							tx_fcs_o <= 1'b1;
							state    <= hdlc_ctl_pkg::TX_FCS;
						end else begin
							state <= hdlc_ctl_pkg::TX_IDLE;
						end
					end
				end
				hdlc_ctl_pkg::TX_FCS: begin
					if (tx_ready_i) begin
						tx_fcs_o <= 1'b0;
						state    <= hdlc_ctl_pkg::TX_IDLE;
					end
				end
				default: state <= hdlc_ctl_pkg::TX_IDLE;
			endcase
		end
	end

	// Byte counter counts sent bytes down; a byte sent at one reloads it only in cycle mode, else it stops at zero.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			byte_cnt        <= hdlc_ctl_pkg::ZERO_BYTE;
			byte_cnt_wrap_o <= 1'b0;
		end else if (wr_i && addr_i == hdlc_ctl_pkg::OFS_BYTE_CNT) begin
			byte_cnt        <= wdata_i;
			byte_cnt_wrap_o <= 1'b0;
		end else if (byte_done && byte_cnt != hdlc_ctl_pkg::ZERO_BYTE) begin
			if (byte_cnt == 8'h01 && ctrl2[hdlc_ctl_pkg::C2_CYCLE_BIT]) begin
				byte_cnt        <= cnt_load;
				byte_cnt_wrap_o <= 1'b1;
			end else begin
				byte_cnt        <= byte_cnt - 8'h01;
				byte_cnt_wrap_o <= 1'b0;
			end
		end else begin
			byte_cnt_wrap_o <= 1'b0;
		end
	end

	// Interrupt bit 2 source selection and FIFO space flag.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			irq_bit2_o      <= 1'b0;
			tx_fifo_ready_o <= 1'b0;
		end else begin
			irq_bit2_o      <= ctrl2[hdlc_ctl_pkg::C2_INTSEL_BIT] ? underrun : abort_ev;
			tx_fifo_ready_o <= txq.in_ready;
		end
	end

	// Address recognition on the first received byte.
	always_comb begin
		if (ctrl2[hdlc_ctl_pkg::C2_SEVEN_BIT]) begin
			addr_hit = rx_byte_i[0] && (rx_byte_i[7:1] == rx_addr[7:1]);
		end else begin
			addr_hit = (rx_byte_i == rx_addr);
		end
	end

	// The first-byte compare result is held until the next first byte arrives.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			addr_match_o <= 1'b0;
		end else if (rx_valid_i && rx_first_i) begin
			addr_match_o <= addr_hit;
		end
	end

	// An end-tagged, non-aborted byte accepted by the link opens the FCS decision.
	sequence eop_byte_taken;
		state == hdlc_ctl_pkg::TX_SEND && tx_ready_i && held_eop && !held_abort;
	endsequence

	chk_tx_empty_code: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rd_i && addr_i == hdlc_ctl_pkg::OFS_STATUS && txq.level == 6'h00
		|=> rdata_o[3:2] == 2'h2)
		else $error("TX empty code wrong");
	chk_tx_full_code: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rd_i && addr_i == hdlc_ctl_pkg::OFS_STATUS && txq.level != 6'h00
		&& txq.level >= stat_lvl |=> rdata_o[3:2] == 2'h0)
		else $error("TX full code wrong");
	chk_rx_code_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rd_i && addr_i == hdlc_ctl_pkg::OFS_STATUS && rx_level_i == 6'h00
		|=> rdata_o[1:0] == 2'h0 && rdata_o[7:4] == 4'h0)
		else $error("RX empty code wrong");
	chk_irq_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		abort_ev && !ctrl2[hdlc_ctl_pkg::C2_INTSEL_BIT] |=> irq_bit2_o)
		else $error("Frame abort not on bit 2");
	chk_irq_underrun: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		underrun && ctrl2[hdlc_ctl_pkg::C2_INTSEL_BIT] |=> irq_bit2_o)
		else $error("Underrun not on bit 2");
	chk_cycle_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		byte_done && byte_cnt == 8'h01 && ctrl2[hdlc_ctl_pkg::C2_CYCLE_BIT]
		&& !wr_i |=> byte_cnt == $past(cnt_load) && byte_cnt_wrap_o)
		else $error("Byte count did not reload");
	chk_crc_inhibit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		eop_byte_taken and ctrl2[hdlc_ctl_pkg::C2_CRCINH_BIT] |=> !tx_fcs_o [*2])
		else $error("FCS sent while inhibited");
	chk_crc_sent: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		eop_byte_taken and !ctrl2[hdlc_ctl_pkg::C2_CRCINH_BIT] |=> tx_fcs_o)
		else $error("FCS missing after end byte");
	chk_seven_bit0: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rx_valid_i && rx_first_i && ctrl2[hdlc_ctl_pkg::C2_SEVEN_BIT] && !rx_byte_i[0]
		|=> !addr_match_o)
		else $error("Seven-bit address matched with bit 0 clear");
endmodule : hdlc_fifo_ctrl2
`default_nettype wire

//--- rtl/hdlc_ctl_pkg.sv
// Constants shared by the HDLC status and second control block.
package hdlc_ctl_pkg;
	localparam int          DATA_W        = 8;
	localparam int          FIFO_W        = 10;
	localparam int          FIFO_DEPTH    = 32;
	localparam int          LEVEL_W       = 6;
	localparam logic [7:0]  OFS_TX_FIFO   = 8'h12;
	localparam logic [7:0]  OFS_CTRL1     = 8'h13;
	localparam logic [7:0]  OFS_STATUS    = 8'h14;
	localparam logic [7:0]  OFS_CTRL2     = 8'h15;
	localparam logic [7:0]  OFS_BYTE_CNT  = 8'h1A;
	localparam logic [7:0]  OFS_ADDR      = 8'h1B;
	localparam logic [7:0]  OFS_STAT_LVL  = 8'h1C;
	localparam logic [7:0]  OFS_INT_THR   = 8'h1D;
	localparam int          C1_EOP_BIT    = 4;
	localparam int          C1_ABORT_BIT  = 3;
	localparam int          C2_INTSEL_BIT = 7;
	localparam int          C2_CYCLE_BIT  = 6;
	localparam int          C2_CRCINH_BIT = 5;
	localparam int          C2_SEVEN_BIT  = 4;
	localparam int          ST_TX_LO_BIT  = 2;
	localparam int          ST_RX_LO_BIT  = 0;
	localparam int          TAG_EOP_BIT   = 8;
	localparam int          TAG_ABORT_BIT = 9;
	localparam logic [7:0]  CTRL2_RESET   = 8'h00;
	localparam logic [7:0]  ZERO_BYTE     = 8'h00;
	localparam logic [5:0]  STAT_LVL_RST  = 6'h10;
	localparam logic [5:0]  INT_THR_RST   = 6'h08;
	localparam logic [1:0]  TX_FULL       = 2'h0;
	localparam logic [1:0]  TX_ABOVE_THR  = 2'h1;
	localparam logic [1:0]  TX_EMPTY      = 2'h2;
	localparam logic [1:0]  TX_BELOW_THR  = 2'h3;
	localparam logic [1:0]  RX_EMPTY      = 2'h0;
	localparam logic [1:0]  RX_BELOW_THR  = 2'h1;
	localparam logic [1:0]  RX_FULL       = 2'h2;
	localparam logic [1:0]  RX_ABOVE_THR  = 2'h3;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_FCS  = 2'b10
	} tx_state_type;
endpackage : hdlc_ctl_pkg

//--- rtl/byte_fifo_if.sv
// Interface joining the transmit data path to its FIFO.
`timescale 1ns/10ps
`default_nettype none
interface byte_fifo_if #(parameter int WIDTH = 10, parameter int LVL_W = 6);
	logic [WIDTH-1:0] in_data;
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] out_data;
	logic             out_valid;
	logic             out_ready;
	logic [LVL_W-1:0] level;
	modport fill  (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid, level);
	modport store (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid, level);
endinterface : byte_fifo_if
`default_nettype wire

//--- rtl/byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides and an occupancy count.
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32,
	parameter int LVL_W = 6
) (
	input  wire logic   clk_i,
	input  wire logic   rst_b_i,
	byte_fifo_if.store  fifo
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr;
	logic [PTR_W-1:0] rptr;
	logic [LVL_W-1:0] count;
	logic             push;
	logic             pop;

	// Handshakes complete only when the matching side is ready.
	assign fifo.in_ready  = (count != LVL_W'(DEPTH));
	assign fifo.out_valid = (count != '0);
	assign fifo.out_data  = mem[rptr];
	assign fifo.level     = count;
	assign push           = fifo.in_valid && fifo.in_ready;
	assign pop            = fifo.out_valid && fifo.out_ready;

	// Storage array is written without reset.
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr] <= fifo.in_data;
		end
	end

	// Pointers and occupancy.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wptr <= wptr + 1'b1;
			end
			if (pop) begin
				rptr <= rptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	chk_count_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		count <= LVL_W'(DEPTH))
		else $error("FIFO occupancy above depth");
endmodule : byte_fifo
`default_nettype wire

//--- dv/hdlc_link_partner.sv
// Remote station model: takes transmit bytes and FCS slots, sends receive bytes.
`timescale 1ns/10ps
`default_nettype none
module hdlc_link_partner (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic       tx_valid_i,
	input  wire logic       tx_fcs_i,
	input  wire logic       stall_i,
	input  wire logic [1:0] slow_i,
	output logic            tx_ready_o,
	output logic [7:0]      rx_byte_o,
	output logic            rx_first_o,
	output logic            rx_valid_o
);
	logic [7:0] got[$];
	int         fcs_cnt = 0;
	logic [1:0] wait_cnt;

	// Acknowledge a pending byte or FCS slot after slow_i extra cycles, one cycle wide.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || stall_i || tx_ready_o || !(tx_valid_i || tx_fcs_i)) begin
			tx_ready_o <= 1'b0;
			wait_cnt   <= 2'h0;
		end else if (wait_cnt >= slow_i) begin
			tx_ready_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end

	// Record every byte and FCS slot that the link takes.
	always @(posedge clk_i) begin
		if (tx_ready_o && tx_valid_i) got.push_back(tx_byte_i);
		if (tx_ready_o && tx_fcs_i) fcs_cnt++;
	end

	initial begin
		rx_byte_o  = 8'h00;
		rx_first_o = 1'b0;
		rx_valid_o = 1'b0;
	end

	// Send one receive byte; afterwards the data line shows the inverse, not a stale copy.
	task automatic send_rx(input logic [7:0] b, input logic first);
		@(posedge clk_i);
		rx_byte_o  <= b;
		rx_first_o <= first;
		rx_valid_o <= 1'b1;
		@(posedge clk_i);
		rx_byte_o  <= ~b;
		rx_first_o <= 1'b0;
		rx_valid_o <= 1'b0;
	endtask : send_rx
endmodule : hdlc_link_partner
`default_nettype wire

//--- dv/test_hdlc_fifo_ctrl2.sv
// Self-checking testbench for the HDLC status and second control block.
`timescale 1ns/10ps
`default_nettype none
module test_hdlc_fifo_ctrl2;
	logic       clk_i;
	logic       rst_b_i;
	logic [7:0] addr_i;
	logic [7:0] wdata_i;
	logic       wr_i;
	logic       rd_i;
	logic [7:0] rdata_o;
	logic       tx_fifo_ready_o;
	logic [7:0] tx_byte_o;
	logic       tx_valid_o;
	logic       tx_packet_end_tag_o;
	logic       tx_fcs_o;
	logic       tx_ready_i;
	logic       irq_bit2_o;
	logic       byte_cnt_wrap_o;
	logic [5:0] rx_level_i;
	logic [7:0] rx_byte_i;
	logic       rx_first_i;
	logic       rx_valid_i;
	logic       addr_match_o;
	logic       stall;
	logic [1:0] slow;
	int         errors = 0;
	int         n_compared = 0;
	int         cycles = 0;
	int         irq_cnt = 0;
	int         wrap_cnt = 0;
	int         eop_cnt = 0;

	hdlc_fifo_ctrl2 hdlc_fifo_ctrl2_inst (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .tx_fifo_ready_o, .tx_byte_o, .tx_valid_o, .tx_packet_end_tag_o, .tx_fcs_o,
		.tx_ready_i, .irq_bit2_o, .byte_cnt_wrap_o, .rx_level_i, .rx_byte_i, .rx_first_i,
		.rx_valid_i, .addr_match_o);

	hdlc_link_partner hdlc_link_partner_inst (.clk_i, .rst_b_i, .tx_byte_i(tx_byte_o),
		.tx_valid_i(tx_valid_o), .tx_fcs_i(tx_fcs_o), .stall_i(stall), .slow_i(slow),
		.tx_ready_o(tx_ready_i), .rx_byte_o(rx_byte_i), .rx_first_o(rx_first_i),
		.rx_valid_o(rx_valid_i));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Count event pulses and cut a hang short.
	always @(posedge clk_i) begin
		cycles++;
		if (irq_bit2_o === 1'b1) irq_cnt++;
		if (byte_cnt_wrap_o === 1'b1) wrap_cnt++;
		if (tx_packet_end_tag_o === 1'b1 && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) eop_cnt++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	task automatic results();
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
		#1 check(rdata_o, exp);
		// Return on a rising edge so that the next stimulus lands on an edge.
		@(posedge clk_i);
	endtask : rd_check

	// Push one byte through the link, wait for the partner to take it and compare it.
	task automatic send(input logic [7:0] c1, input logic [7:0] d);
		int n;
		n = hdlc_link_partner_inst.got.size();
		if (c1 != 8'h00) wr(hdlc_ctl_pkg::OFS_CTRL1, c1);
		wr(hdlc_ctl_pkg::OFS_TX_FIFO, d);
		for (int i = 0; i < 100 && hdlc_link_partner_inst.got.size() == n; i++) @(posedge clk_i);
		repeat (8) @(posedge clk_i);
		check(hdlc_link_partner_inst.got.pop_back(), d);
	endtask : send

	task automatic t_reset();
		rd_check(hdlc_ctl_pkg::OFS_CTRL2, 8'h00);
		check({7'h0, tx_fifo_ready_o}, 8'h01);
		rd_check(hdlc_ctl_pkg::OFS_STATUS, 8'h08);
		wr(8'h3F, 8'hFF);
		rd_check(8'h3F, 8'h00);
		wr(hdlc_ctl_pkg::OFS_CTRL2, 8'hA7);
		rd_check(hdlc_ctl_pkg::OFS_CTRL2, 8'hA7);
	endtask : t_reset

	task automatic t_rx_status();
		logic [5:0] lv [5] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h20};
		logic [1:0] cd [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2};
		for (int i = 0; i < 5; i++) begin
			rx_level_i <= lv[i];
			rd_check(hdlc_ctl_pkg::OFS_STATUS, {4'h2, cd[i]});
		end
		rx_level_i <= 6'h00;
	endtask : t_rx_status

	// Fill the transmit FIFO against a stalled link, then drain it in order.
	task automatic t_tx_status();
		int         lvl;
		logic [1:0] code;
		stall <= 1'b1;
		wr(hdlc_ctl_pkg::OFS_CTRL2, 8'h00);
		wr(hdlc_ctl_pkg::OFS_STAT_LVL, 8'h04);
		wr(hdlc_ctl_pkg::OFS_INT_THR, 8'h02);
		for (int n = 1; n <= 34; n++) begin
			wr(hdlc_ctl_pkg::OFS_TX_FIFO, 8'(n));
			repeat (3) @(posedge clk_i);
			lvl  = (n > 33) ? 32 : n - 1;
			code = (lvl == 0) ? 2'h2 : (lvl >= 4) ? 2'h0 : (lvl >= 2) ? 2'h1 : 2'h3;
			if (n <= 6 || n >= 33) rd_check(hdlc_ctl_pkg::OFS_STATUS, {4'h0, code, 2'h0});
		end
		check({7'h0, tx_fifo_ready_o}, 8'h00);
		stall <= 1'b0;
		repeat (400) @(posedge clk_i);
		check(8'(hdlc_link_partner_inst.got.size()), 8'd33);
		for (int n = 1; n <= 33; n++) check(hdlc_link_partner_inst.got.pop_front(), 8'(n));
		rd_check(hdlc_ctl_pkg::OFS_STATUS, 8'h08);
	endtask : t_tx_status

	// Tag and mode combinations: FCS slots and the interrupt bit 2 event.
	task automatic t_tags();
		logic [7:0] c2 [7] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
		logic [7:0] c1 [7] = '{8'h10, 8'h10, 8'h08, 8'h00, 8'h00, 8'h08, 8'h10};
		logic [7:0] fc [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		logic [7:0] ir [7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
		int f;
		int q;
		int e;
		slow <= 2'h2;
		for (int i = 0; i < 7; i++) begin
			wr(hdlc_ctl_pkg::OFS_CTRL2, c2[i]);
			f = hdlc_link_partner_inst.fcs_cnt;
			q = irq_cnt;
			e = eop_cnt;
			send(c1[i], 8'h50 + 8'(i));
			check(8'(eop_cnt - e), {7'h0, c1[i][hdlc_ctl_pkg::C1_EOP_BIT]});
			check(8'(hdlc_link_partner_inst.fcs_cnt - f), fc[i]);
			check(8'(irq_cnt - q), ir[i]);
		end
		slow <= 2'h0;
	endtask : t_tags

	task automatic t_counter();
		int w;
		for (int c = 1; c >= 0; c--) begin
			wr(hdlc_ctl_pkg::OFS_CTRL2, (c == 1) ? 8'h40 : 8'h00);
			wr(hdlc_ctl_pkg::OFS_BYTE_CNT, 8'h03);
			w = wrap_cnt;
			for (int i = 0; i < 6; i++) send(8'h00, 8'hC0 + 8'(i));
			check(8'(wrap_cnt - w), (c == 1) ? 8'h02 : 8'h00);
			rd_check(hdlc_ctl_pkg::OFS_BYTE_CNT, (c == 1) ? 8'h03 : 8'h00);
		end
	endtask : t_counter

	task automatic t_addr();
		logic [7:0] c2 [5] = '{8'h10, 8'h10, 8'h10, 8'h00, 8'h00};
		logic [7:0] rb [5] = '{8'hA5, 8'hA4, 8'hA7, 8'hA4, 8'hA5};
		logic [7:0] ex [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
		wr(hdlc_ctl_pkg::OFS_ADDR, 8'hA4);
		for (int i = 0; i < 5; i++) begin
			wr(hdlc_ctl_pkg::OFS_CTRL2, c2[i]);
			hdlc_link_partner_inst.send_rx(rb[i], 1'b1);
			repeat (2) @(posedge clk_i);
			check({7'h0, addr_match_o}, ex[i]);
		end
	endtask : t_addr

	initial begin
		rst_b_i    = 1'b0;
		addr_i     = 8'h00;
		wdata_i    = 8'h00;
		wr_i       = 1'b0;
		rd_i       = 1'b0;
		rx_level_i = 6'h00;
		stall      = 1'b0;
		slow       = 2'h0;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_rx_status();
		t_tx_status();
		t_tags();
		t_counter();
		t_addr();
		results();
	end
endmodule : test_hdlc_fifo_ctrl2
`default_nettype wire
